/* File: hw/capture_map.svh */
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH
// ----------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------
`define OFS_EDGE_SELECT   12'ha04
`define OFS_START_STOP    12'ha08
`define OFS_ENC_SOURCE    12'ha14
`define OFS_RESULT_LO     12'ha80
`define OFS_RESULT_HI     12'ha82
`define OFS_STATUS        12'ha84
// ----------------------------------------------------------------
// Setting values and reset values
// ----------------------------------------------------------------
`define CMD_STOP          16'h0000
`define CMD_ONCE          16'h0001
`define CMD_CONT          16'h0002
`define CMD_MAX           16'h0004
`define EDGE_FALL         16'h0000
`define EDGE_RISE         16'h0001
`define EDGE_BOTH         16'h0002
`define SRC_ENC1          16'h0000
`define RST_EDGE_SELECT   16'h0000
`define RST_START_STOP    16'h0000
`define RST_ENC_SOURCE    16'h0000
// ----------------------------------------------------------------
// Status word bits
// ----------------------------------------------------------------
`define ST_NEW            0
`define ST_OVERRUN        1
`define ST_ACTIVE         2
`endif

/* File: hw/capture_pkg.sv */
`default_nettype none
package capture_pkg;
    // Parameter access request from the fieldbus side
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } par_req_t;
    // Answer, one cycle after the request
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } par_rsp_t;
    // Run state, Gray along stop -> once -> continuous
    typedef enum logic [1:0] {
        RUN_STOP = 2'b00,
        RUN_ONCE = 2'b01,
        RUN_CONT = 2'b11
    } run_state_t;
endpackage
`default_nettype wire

/* File: hw/capture_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_sync (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stage;
    logic       next_level;
    // ----------------------------------------------------------------
    // Three-stage synchroniser with agreement filter
    // ----------------------------------------------------------------
    // Only stages two and three are compared; stage one may be metastable
    always_comb begin
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= {stage[1:0], pin};
            level <= next_level;
        end
    end
endmodule // capture_sync
`default_nettype wire

/* File: hw/position_capture_input_unit.sv */
`include "capture_map.svh"
`timescale 1ns/1ps
`default_nettype none
module position_capture_input_unit
    import capture_pkg::*;
#(
    parameter int POS_W = 32
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 capture_pin,
    input  wire logic [POS_W-1:0]     enc1_position,
    input  wire par_req_t             par_req,
    output par_rsp_t                  par_rsp,
    output logic                      capture_strobe,
    output logic                      capture_active
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Address match used by write, read and validation paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    logic                 pin_level;
    logic                 pin_prev;
    logic                 edge_rise;
    logic                 edge_fall;
    logic                 qualify;
    logic                 take;
    logic [15:0]          edge_select;
    logic [15:0]          start_stop;
    logic [15:0]          enc_source;
    logic [POS_W-1:0]     result;
    logic                 flag_new;
    logic                 flag_overrun;
    run_state_t           state;
    logic [15:0]          next_edge_select;
    logic [15:0]          next_start_stop;
    logic [15:0]          next_enc_source;
    logic [POS_W-1:0]     next_result;
    logic                 next_flag_new;
    logic                 next_flag_overrun;
    run_state_t           next_state;
    par_rsp_t             next_rsp;
    logic                 wr_ss;
    logic                 wr_ok;
    logic                 wr_bad;
    logic [31:0]          result_w;

    capture_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin      (capture_pin),
        .level    (pin_level)
    );

    // ----------------------------------------------------------------
    // Edge qualification
    // ----------------------------------------------------------------
    // Source other than encoder 1 can never be stored, so it gates nothing extra
    always_comb begin
        edge_rise = pin_level & ~pin_prev;
        edge_fall = ~pin_level & pin_prev;
        case (edge_select)
            `EDGE_FALL: qualify = edge_fall;
            `EDGE_RISE: qualify = edge_rise;
            `EDGE_BOTH: qualify = edge_rise | edge_fall;
            default:    qualify = 1'b0;
        endcase
        take = qualify && (state != RUN_STOP) && (enc_source == `SRC_ENC1);
    end

    // ----------------------------------------------------------------
    // Parameter write validation
    // ----------------------------------------------------------------
    // Out-of-range values are refused so the stored setting stays decodable
    always_comb begin
        wr_ss  = par_req.wr && hit(par_req.addr, `OFS_START_STOP);
        wr_ok  = 1'b0;
        if (par_req.wr) begin
            if (hit(par_req.addr, `OFS_EDGE_SELECT))
                wr_ok = (par_req.wdata <= `EDGE_BOTH);
            else if (wr_ss)
                wr_ok = (par_req.wdata <= `CMD_MAX);
            else if (hit(par_req.addr, `OFS_ENC_SOURCE))
                wr_ok = (par_req.wdata == `SRC_ENC1);
            else if (hit(par_req.addr, `OFS_STATUS))
                wr_ok = 1'b1;
        end
        wr_bad = par_req.wr && !wr_ok;
    end

    // ----------------------------------------------------------------
    // Settings and run state
    // ----------------------------------------------------------------
    // A start/stop write in the capture cycle wins: the newer command counts
    always_comb begin
        next_edge_select = edge_select;
        next_start_stop  = start_stop;
        next_enc_source  = enc_source;
        next_state       = state;
        if (take && state == RUN_ONCE) begin
            next_start_stop = `CMD_STOP;
            next_state      = RUN_STOP;
        end
        if (wr_ok && hit(par_req.addr, `OFS_EDGE_SELECT))
            next_edge_select = par_req.wdata;
        if (wr_ok && hit(par_req.addr, `OFS_ENC_SOURCE))
            next_enc_source = par_req.wdata;
        if (wr_ok && wr_ss) begin
            next_start_stop = par_req.wdata;
            case (par_req.wdata)
                `CMD_ONCE: next_state = RUN_ONCE;
                `CMD_CONT: next_state = RUN_CONT;
                default:   next_state = RUN_STOP;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Result and flags
    // ----------------------------------------------------------------
    // Set beats a write-one clear in the same cycle
    always_comb begin
        next_result       = result;
        next_flag_new     = flag_new;
        next_flag_overrun = flag_overrun;
        if (wr_ok && hit(par_req.addr, `OFS_STATUS)) begin
            if (par_req.wdata[`ST_NEW])
                next_flag_new = 1'b0;
            if (par_req.wdata[`ST_OVERRUN])
                next_flag_overrun = 1'b0;
        end
        if (take) begin
            next_result   = enc1_position;
            next_flag_new = 1'b1;
            if (flag_new)
                next_flag_overrun = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read answer
    // ----------------------------------------------------------------
    // Result is read in two halves; no snapshot, so read with the flag set
    always_comb begin
        result_w      = 32'(result);
        next_rsp      = '0;
        next_rsp.ack  = par_req.wr | par_req.rd;
        next_rsp.err  = wr_bad;
        if (par_req.rd && !par_req.wr) begin
            if (hit(par_req.addr, `OFS_EDGE_SELECT))
                next_rsp.rdata = edge_select;
            else if (hit(par_req.addr, `OFS_START_STOP))
                next_rsp.rdata = start_stop;
            else if (hit(par_req.addr, `OFS_ENC_SOURCE))
                next_rsp.rdata = enc_source;
            else if (hit(par_req.addr, `OFS_RESULT_LO))
                next_rsp.rdata = result_w[15:0];
            else if (hit(par_req.addr, `OFS_RESULT_HI))
                next_rsp.rdata = result_w[31:16];
            else if (hit(par_req.addr, `OFS_STATUS)) begin
                next_rsp.rdata[`ST_NEW]     = flag_new;
                next_rsp.rdata[`ST_OVERRUN] = flag_overrun;
                next_rsp.rdata[`ST_ACTIVE]  = (state != RUN_STOP);
            end else
                next_rsp.err = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_prev       <= 1'b0;
            edge_select    <= `RST_EDGE_SELECT;
            start_stop     <= `RST_START_STOP;
            enc_source     <= `RST_ENC_SOURCE;
            state          <= RUN_STOP;
            result         <= '0;
            flag_new       <= 1'b0;
            flag_overrun   <= 1'b0;
            par_rsp        <= '0;
            capture_strobe <= 1'b0;
            capture_active <= 1'b0;
        end else begin
            pin_prev       <= pin_level;
            edge_select    <= next_edge_select;
            start_stop     <= next_start_stop;
            enc_source     <= next_enc_source;
            state          <= next_state;
            result         <= next_result;
            flag_new       <= next_flag_new;
            flag_overrun   <= next_flag_overrun;
            par_rsp        <= next_rsp;
            capture_strobe <= take;
            capture_active <= (next_state != RUN_STOP);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_once_armed;
        state == RUN_ONCE && !par_req.wr;
    endsequence
    sequence s_took;
        take;
    endsequence

    stop_cancels_a: assert property (wr_ok && wr_ss && par_req.wdata == `CMD_STOP |=> state == RUN_STOP)
        else $error("stop write did not cancel capture");
    once_ends_a: assert property (s_once_armed ##0 s_took |=> state == RUN_STOP && start_stop == `CMD_STOP)
        else $error("single capture did not end");
    cont_keeps_a: assert property (state == RUN_CONT && !par_req.wr |=> state == RUN_CONT)
        else $error("continuous capture stopped by itself");
    fall_edge_a: assert property (edge_select == `EDGE_FALL && take |-> !pin_level && pin_prev)
        else $error("falling-edge capture on wrong edge");
    rise_edge_a: assert property (edge_select == `EDGE_RISE && state != RUN_STOP && edge_rise
                                  |=> capture_strobe)
        else $error("rising edge missed");
    both_edge_a: assert property (edge_select == `EDGE_BOTH && state != RUN_STOP && (edge_rise || edge_fall)
                                  |=> capture_strobe)
        else $error("edge missed in both-edge mode");
    source_only_a: assert property (par_req.wr && hit(par_req.addr, `OFS_ENC_SOURCE) && par_req.wdata != `SRC_ENC1
                                    |=> par_rsp.err && enc_source == `SRC_ENC1)
        else $error("unsupported source accepted");
    apply_now_a: assert property (wr_ok && hit(par_req.addr, `OFS_EDGE_SELECT)
                                  |=> edge_select == $past(par_req.wdata))
        else $error("edge setting not applied at once");
    // A write-one clear right after the capture may legally drop the flag again
    result_latch_a: assert property (s_took |=> result == $past(enc1_position) && flag_new
                                     ##1 (flag_new || take || $past(wr_ok && hit(par_req.addr, `OFS_STATUS))))
        else $error("captured position or flag wrong");
endmodule // position_capture_input_unit
`default_nettype wire

/* File: bench/capture_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Far side: capture signal source and encoder 1 position
// ----------------------------------------------------------------
module capture_partner #(
    parameter int POS_W = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             level_cmd,
    input  wire logic [POS_W-1:0] pos_cmd,
    output logic                  capture_pin,
    output logic [POS_W-1:0]      enc1_position
);
    // Registered so the pin only moves in the clock edge's own time step
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            capture_pin   <= 1'b0;
            enc1_position <= '0;
        end else begin
            capture_pin   <= level_cmd;
            enc1_position <= pos_cmd;  // Held while an edge is in flight
        end
    end
endmodule // capture_partner
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "capture_map.svh"
module testbench
    import capture_pkg::*;
;
    localparam int POS_W = 32;
    logic             core_clk;
    logic             rst_b;
    logic             level_cmd;
    logic [POS_W-1:0] pos_cmd;
    logic             capture_pin;
    logic [POS_W-1:0] enc1_position;
    par_req_t         par_req;
    par_rsp_t         par_rsp;
    logic             capture_strobe;
    logic             capture_active;
    logic [16:0]      exp_q[$];
    int               num_errors;
    int               samples_checked;
    int               strobes;
    logic [POS_W-1:0] pos;
    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;
    position_capture_input_unit #(.POS_W(POS_W)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .capture_pin(capture_pin), .enc1_position(enc1_position),
        .par_req(par_req), .par_rsp(par_rsp), .capture_strobe(capture_strobe), .capture_active(capture_active));
    capture_partner #(.POS_W(POS_W)) partner (
        .core_clk(core_clk), .rst_b(rst_b), .level_cmd(level_cmd), .pos_cmd(pos_cmd),
        .capture_pin(capture_pin), .enc1_position(enc1_position));
    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Oldest note against each answer; a stray answer is a mismatch
    always @(posedge core_clk) begin
        if (capture_strobe === 1'b1) strobes++;
        if (par_rsp.ack === 1'b1) begin
            if (exp_q.size() == 0) check(17'h1ffff, 17'h0);
            else check({par_rsp.err, par_rsp.rdata}, exp_q.pop_front());
        end
    end
    // ----------------------------------------------------------------
    // Stimulus tasks
    // ----------------------------------------------------------------
    // One request, one cycle wide, with its expected answer noted
    task automatic bus(input logic wr, input logic [11:0] addr, input logic [15:0] data, input logic [16:0] exp);
        @(posedge core_clk);
        #2;
        par_req = '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        exp_q.push_back(exp);
        @(posedge core_clk);
        #2;
        par_req = '0;
    endtask
    // Fixed window well past the filter latency, so doubles show too
    task automatic edge_to(input logic lvl, input logic hit);
        int n;
        pos = $urandom();
        @(posedge core_clk);
        #2;
        pos_cmd = pos;
        @(posedge core_clk);
        #2;
        level_cmd = lvl;
        n = strobes;
        repeat (12) @(posedge core_clk);
        #2;
        check(17'(strobes - n), {16'h0, hit});
    endtask
    // Collect the latched value, then clear the status flags
    task automatic read_result(input logic [15:0] st);
        bus(1'b0, `OFS_RESULT_LO, 16'h0, {1'b0, pos[15:0]});
        bus(1'b0, `OFS_RESULT_HI, 16'h0, {1'b0, pos[31:16]});
        bus(1'b0, `OFS_STATUS, 16'h0, {1'b0, st});
        bus(1'b1, `OFS_STATUS, 16'h0003, 17'h0);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        par_req = '0;
        level_cmd = 1'b0;
        pos_cmd = '0;
        rst_b = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        strobes = 0;
        pos = $urandom(37);
        repeat (20) @(posedge core_clk);
        #2;
        rst_b = 1'b1;
        // Reset values, unmapped place and refused writes
        bus(1'b0, `OFS_EDGE_SELECT, 16'h0, {1'b0, `RST_EDGE_SELECT});
        bus(1'b0, `OFS_START_STOP, 16'h0, {1'b0, `RST_START_STOP});
        bus(1'b0, `OFS_ENC_SOURCE, 16'h0, {1'b0, `RST_ENC_SOURCE});
        bus(1'b0, 12'ha00, 16'h0, 17'h10000);
        bus(1'b1, `OFS_ENC_SOURCE, 16'h0001, 17'h10000);
        bus(1'b0, `OFS_ENC_SOURCE, 16'h0, 17'h0);
        bus(1'b1, `OFS_EDGE_SELECT, 16'h0003, 17'h10000);
        bus(1'b1, `OFS_ENC_SOURCE, `SRC_ENC1, 17'h0);
        edge_to(1'b1, 1'b0);
        // Single capture on rising edge, ends by itself
        bus(1'b1, `OFS_EDGE_SELECT, `EDGE_RISE, 17'h0);
        bus(1'b1, `OFS_START_STOP, `CMD_ONCE, 17'h0);
        check({16'h0, capture_active}, 17'h1);
        edge_to(1'b0, 1'b0);
        edge_to(1'b1, 1'b1);
        read_result(16'h0001);
        check({16'h0, capture_active}, 17'h0);
        bus(1'b0, `OFS_START_STOP, 16'h0, 17'h0);
        edge_to(1'b0, 1'b0);
        edge_to(1'b1, 1'b0);
        // Continuous capture on both edges
        bus(1'b1, `OFS_EDGE_SELECT, `EDGE_BOTH, 17'h0);
        bus(1'b1, `OFS_START_STOP, `CMD_CONT, 17'h0);
        for (int i = 0; i < 4; i++) begin
            edge_to(~level_cmd, 1'b1);
            read_result(16'h0005);
        end
        // Two captures left unread raise the overrun bit
        edge_to(~level_cmd, 1'b1);
        edge_to(~level_cmd, 1'b1);
        read_result(16'h0007);
        bus(1'b0, `OFS_START_STOP, 16'h0, {1'b0, `CMD_CONT});
        // Edge change while running acts at once
        bus(1'b1, `OFS_EDGE_SELECT, `EDGE_FALL, 17'h0);
        edge_to(1'b0, 1'b1);
        read_result(16'h0005);
        edge_to(1'b1, 1'b0);
        // Cancel stops further captures
        bus(1'b1, `OFS_START_STOP, `CMD_STOP, 17'h0);
        edge_to(1'b0, 1'b0);
        // Stored values above continuous act as stop; beyond the range refused
        bus(1'b1, `OFS_EDGE_SELECT, `EDGE_BOTH, 17'h0);
        bus(1'b1, `OFS_START_STOP, `CMD_MAX, 17'h0);
        check({16'h0, capture_active}, 17'h0);
        edge_to(1'b1, 1'b0);
        bus(1'b1, `OFS_START_STOP, 16'h0005, 17'h10000);
        bus(1'b0, `OFS_START_STOP, 16'h0, {1'b0, `CMD_MAX});
        bus(1'b1, `OFS_RESULT_LO, 16'h0, 17'h10000);
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge core_clk);
        if (exp_q.size() != 0) num_errors++;
        give_verdict();
    end
    // Hang guard
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
